// ===== core/pwr_mode_seq.sv
// power-mode sequencer: shutdown pin, sleep control, apb registers, tdm output
// assumes APB on CLK; BCLK/FSYNC from the host, unrelated to CLK
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: shutdown pin low during supply ramp keeps device in hardware shutdown.
// RULE_02: host releases shutdown pin only once both supplies are steady.
// RULE_03: after pin release device initialises registers for 1 ms, then sleeps.
// RULE_04: writing sleep control with sleep disabled starts the wake-up sequence.
// RULE_05: host waits at least 1 ms after each wake-up write.
// RULE_06: host may rewrite configuration after wake-up, before enabling channels.
// RULE_07: only channels enabled in the input channel register are recorded.
// RULE_08: only enabled output slots are driven on the serial bus.
// RULE_09: converter, bias and pll power follow the power control register.
// RULE_10: host supplies frame sync and bit clock any time after wake-up write.
// RULE_11: configured and clocked, device streams recorded samples over tdm.
// RULE_12: writing sleep enabled ramps volume down and powers blocks off.
// RULE_13: host waits at least 6 ms after requesting sleep.
// RULE_14: status register bit 7 reads one once sleep is reached.
// RULE_15: register contents are kept through sleep.
// RULE_16: shutdown pin low in any state forces hardware shutdown.
// RULE_17: leaving shutdown repeats the full sequence including 1 ms init.
// RULE_18: no valid samples in shutdown, sleep, or before wake-up completes.
module pwr_mode_seq
    import pwrseq_pkg::*;
#(
    parameter int unsigned INIT_CNT  = pwrseq_pkg::INIT_CYCLES,
    parameter int unsigned WAKE_CNT  = pwrseq_pkg::WAKE_CYCLES,
    parameter int unsigned SLEEP_CNT = pwrseq_pkg::SLEEP_CYCLES,
    parameter int unsigned CHANNELS  = 8
) (
    input  wire logic         CLK,
    input  wire logic         SRST,
    input  wire logic         HW_SHUTDOWN_PIN_N,
    input  wire logic         PSEL,
    input  wire logic         PENABLE,
    input  wire logic         PWRITE,
    input  wire logic [11:0]  PADDR,
    input  wire logic [31:0]  PWDATA,
    output logic [31:0]       PRDATA,
    output logic              PREADY,
    output logic              PSLVERR,
    input  wire logic         BCLK,
    input  wire logic         FSYNC,
    output logic              SDOUT,
    output logic              SDOUT_OE,
    output logic              ADC_POWER_ON,
    output logic              MIC_BIAS_SUPPLY_ON,
    output logic              PLL_POWER_ON
);
    import pwrseq_pkg::*;

    initial begin
        if (CHANNELS != 8) $error("only eight channels are supported");
        if (INIT_CNT == 0 || WAKE_CNT == 0 || SLEEP_CNT == 0) $error("waits must be non-zero");
        if (SLEEP_CNT >= (1 << CNT_W)) $error("wait too long for timer");
    end

    typedef struct packed {
        logic             pin_m;
        logic             pin_s;
        pwr_state_e       state;
        logic [7:0]       sleep_ctrl;
        logic [7:0]       in_ch_en;
        logic [7:0]       out_slot_en;
        logic [7:0]       pwr_ctrl;
        logic [31:0]      sample;
        logic [31:0]      rdata;
        logic             tl_m;
        logic             tl_s;
        logic             tl_d;
        logic             link_seen;
        logic             tmr_load;
        logic [CNT_W-1:0] tmr_val;
        logic [CNT_W-1:0] dwell;
    } seq_s;
    seq_s st_r;
    seq_s st_nxt;

    logic tmr_done;
    logic frame_tgl;
    logic tx_run;

    // register decode used by both the write and read paths
    function automatic logic hit(input logic [11:0] a, input logic [11:0] idx);
        return a == {idx[9:0], 2'b00};
    endfunction

    wire logic acc     = PSEL && PENABLE;
    wire logic wr      = acc && PWRITE;
    wire logic mapped  = hit(PADDR, SLEEP_CTRL_IDX) || hit(PADDR, IN_CH_EN_IDX)
                       || hit(PADDR, OUT_SLOT_EN_IDX) || hit(PADDR, PWR_CTRL_IDX)
                       || hit(PADDR, STATUS_IDX) || hit(PADDR, SAMPLE_IDX);
    wire logic regs_ok = st_r.state != ST_SHUTDOWN && st_r.state != ST_INIT;

    // one always_comb: pin sync, state machine, registers, read data
    always_comb begin
        st_nxt = st_r;
        st_nxt.tmr_load = 1'b0;
        st_nxt.pin_m = HW_SHUTDOWN_PIN_N;
        st_nxt.pin_s = st_r.pin_m;
        st_nxt.tl_m  = frame_tgl;
        st_nxt.tl_s  = st_r.tl_m;
        st_nxt.tl_d  = st_r.tl_s;

        // register writes, only once initialisation is done
        if (wr && regs_ok) begin
            if (hit(PADDR, SLEEP_CTRL_IDX))  st_nxt.sleep_ctrl  = PWDATA[7:0];    // [RULE_04] [RULE_12]
            if (hit(PADDR, IN_CH_EN_IDX))    st_nxt.in_ch_en    = PWDATA[7:0];    // [RULE_07]
            if (hit(PADDR, OUT_SLOT_EN_IDX)) st_nxt.out_slot_en = PWDATA[7:0];    // [RULE_08]
            if (hit(PADDR, PWR_CTRL_IDX))    st_nxt.pwr_ctrl    = PWDATA[7:0];    // [RULE_09]
            if (hit(PADDR, SAMPLE_IDX))      st_nxt.sample      = PWDATA;
        end

        unique case (st_r.state)
            ST_SHUTDOWN: begin
                if (st_r.pin_s) begin                                           // [RULE_01] [RULE_17]
                    st_nxt.state    = ST_INIT;
                    st_nxt.tmr_load = 1'b1;
                    st_nxt.tmr_val  = CNT_W'(INIT_CNT);
                end
            end
            ST_INIT: begin
                if (tmr_done && !st_r.tmr_load) begin                           // [RULE_03]
                    st_nxt.state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!st_r.sleep_ctrl[SLEEP_EN_BIT]) begin                       // [RULE_04]
                    st_nxt.state    = ST_WAKING;
                    st_nxt.tmr_load = 1'b1;
                    st_nxt.tmr_val  = CNT_W'(WAKE_CNT);
                end
            end
            ST_WAKING: begin
                if (tmr_done && !st_r.tmr_load) begin
                    st_nxt.state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (st_r.sleep_ctrl[SLEEP_EN_BIT]) begin                        // [RULE_12]
                    st_nxt.state    = ST_RAMPDOWN;
                    st_nxt.tmr_load = 1'b1;
                    st_nxt.tmr_val  = CNT_W'(SLEEP_CNT);
                end
            end
            ST_RAMPDOWN: begin
                if (tmr_done && !st_r.tmr_load) begin
                    st_nxt.state     = ST_SLEEP;
                    st_nxt.link_seen = 1'b0;
                end
            end
            default: st_nxt.state = ST_SHUTDOWN;
        endcase

        // a frame seen in the clearing cycle still counts
        if (st_r.tl_s != st_r.tl_d) begin
            st_nxt.link_seen = 1'b1;
        end

        // pin low forces shutdown and reloads register defaults
        if (!st_r.pin_s) begin                                                  // [RULE_16]
            st_nxt.state       = ST_SHUTDOWN;
            st_nxt.sleep_ctrl  = SLEEP_CTRL_RST;
            st_nxt.in_ch_en    = IN_CH_EN_RST;
            st_nxt.out_slot_en = OUT_SLOT_EN_RST;
            st_nxt.pwr_ctrl    = PWR_CTRL_RST;
            st_nxt.sample      = '0;
            st_nxt.link_seen   = 1'b0;
        end

        // cycles spent in the current state, saturating
        if (st_nxt.state != st_r.state) begin
            st_nxt.dwell = '0;
        end else if (st_r.dwell != '1) begin
            st_nxt.dwell = st_r.dwell + 1'b1;
        end

        // read data captured in setup phase
        st_nxt.rdata = '0;
        if (PSEL && !PENABLE && !PWRITE) begin
            if (hit(PADDR, SLEEP_CTRL_IDX))  st_nxt.rdata = {24'h0000_00, st_r.sleep_ctrl};
            if (hit(PADDR, IN_CH_EN_IDX))    st_nxt.rdata = {24'h0000_00, st_r.in_ch_en};
            if (hit(PADDR, OUT_SLOT_EN_IDX)) st_nxt.rdata = {24'h0000_00, st_r.out_slot_en};
            if (hit(PADDR, PWR_CTRL_IDX))    st_nxt.rdata = {24'h0000_00, st_r.pwr_ctrl};
            if (hit(PADDR, SAMPLE_IDX))      st_nxt.rdata = st_r.sample;
            if (hit(PADDR, STATUS_IDX)) begin                                   // [RULE_14]
                st_nxt.rdata[STAT_SLEEP_BIT]  = st_r.state == ST_SLEEP;
                st_nxt.rdata[STAT_ACTIVE_BIT] = st_r.state == ST_ACTIVE;
                st_nxt.rdata[STAT_LINK_BIT]   = st_r.link_seen;
                st_nxt.rdata[2:0]             = st_r.state;
            end
        end
    end

    // single register stage for all state
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r             <= '0;
            st_r.state       <= ST_SHUTDOWN;
            st_r.sleep_ctrl  <= SLEEP_CTRL_RST;
            st_r.in_ch_en    <= IN_CH_EN_RST;
            st_r.out_slot_en <= OUT_SLOT_EN_RST;
            st_r.pwr_ctrl    <= PWR_CTRL_RST;
        end else begin
            st_r <= st_nxt;                                                     // [RULE_15]
        end
    end

    pwr_wait_timer #(
        .W        (CNT_W)
    ) u_timer (
        .CLK      (CLK),
        .SRST     (SRST),
        .load     (st_r.tmr_load),
        .load_val (st_r.tmr_val),
        .done     (tmr_done)
    );

    // stream only when active with converter and pll powered
    assign tx_run = st_r.state == ST_ACTIVE && st_r.pwr_ctrl[PWR_ADC_BIT]
                    && st_r.pwr_ctrl[PWR_PLL_BIT] && (st_r.in_ch_en != 8'h00);  // [RULE_11] [RULE_18]

    // slots carry data only for recorded channels
    logic [7:0] slot_mask;
    assign slot_mask = st_r.out_slot_en & st_r.in_ch_en;                        // [RULE_07]

    tdm_slot_tx #(
        .SLOTS         (CHANNELS)
    ) u_tx (
        .BCLK          (BCLK),
        .FSYNC         (FSYNC),
        .run_async     (tx_run),
        .slot_en_async (slot_mask),
        .sample_async  (st_r.sample),
        .sdout         (SDOUT),
        .sdout_oe      (SDOUT_OE),
        .frame_tgl     (frame_tgl)
    );

    // block power follows the register only while active
    assign ADC_POWER_ON       = st_r.state == ST_ACTIVE && st_r.pwr_ctrl[PWR_ADC_BIT];   // [RULE_09]
    assign MIC_BIAS_SUPPLY_ON = st_r.state == ST_ACTIVE && st_r.pwr_ctrl[PWR_BIAS_BIT];
    assign PLL_POWER_ON       = st_r.state == ST_ACTIVE && st_r.pwr_ctrl[PWR_PLL_BIT];

    // apb answers with no wait states; read data registered at setup
    assign PREADY  = 1'b1;
    assign PRDATA  = st_r.rdata;
    assign PSLVERR = acc && (!mapped || (PWRITE && hit(PADDR, STATUS_IDX)));

    a_shutdown_force: assert property (@(posedge CLK) disable iff (SRST)       // [RULE_16]
        !st_r.pin_s |=> st_r.state == ST_SHUTDOWN)
        else $error("pin low did not force shutdown");
    a_init_wait: assert property (@(posedge CLK) disable iff (SRST)            // [RULE_03]
        (st_r.state == ST_INIT && st_nxt.state == ST_SLEEP) |-> st_r.dwell >= INIT_CNT)
        else $error("sleep reached without init wait");
    a_wake_start: assert property (@(posedge CLK) disable iff (SRST)           // [RULE_04]
        (st_r.state == ST_SLEEP && !st_r.sleep_ctrl[SLEEP_EN_BIT] && st_r.pin_s)
        |=> st_r.state == ST_WAKING)
        else $error("wake-up did not start");
    a_sleep_start: assert property (@(posedge CLK) disable iff (SRST)          // [RULE_12]
        (st_r.state == ST_ACTIVE && st_r.sleep_ctrl[SLEEP_EN_BIT] && st_r.pin_s)
        |=> st_r.state == ST_RAMPDOWN)
        else $error("sleep request ignored");
    a_no_power_idle: assert property (@(posedge CLK) disable iff (SRST)        // [RULE_09]
        st_r.state != ST_ACTIVE |-> !ADC_POWER_ON && !PLL_POWER_ON)
        else $error("blocks powered outside active");
    a_status_sleep: assert property (@(posedge CLK) disable iff (SRST)         // [RULE_14]
        (PSEL && !PENABLE && !PWRITE && hit(PADDR, STATUS_IDX) && st_r.state == ST_SLEEP)
        |=> st_r.rdata[STAT_SLEEP_BIT])
        else $error("status sleep bit wrong");
    a_no_tx_idle: assert property (@(posedge CLK) disable iff (SRST)           // [RULE_18]
        st_r.state inside {ST_SHUTDOWN, ST_INIT, ST_SLEEP, ST_WAKING} |-> !tx_run)
        else $error("stream enabled while not active");
    a_regs_kept: assert property (@(posedge CLK) disable iff (SRST)            // [RULE_15]
        (st_r.state == ST_SLEEP && st_r.pin_s && !wr) |=> $stable(st_r.in_ch_en))
        else $error("register lost in sleep");
    a_wake_time: assert property (@(posedge CLK) disable iff (SRST)            // [RULE_04]
        (st_r.state == ST_WAKING && st_nxt.state == ST_ACTIVE) |-> st_r.dwell >= WAKE_CNT)
        else $error("wake-up too short");
    a_ramp_time: assert property (@(posedge CLK) disable iff (SRST)            // [RULE_12]
        (st_r.state == ST_RAMPDOWN && st_nxt.state == ST_SLEEP) |-> st_r.dwell >= SLEEP_CNT)
        else $error("ramp-down too short");
endmodule

// ===== common/pwrseq_pkg.sv
// constants shared by the power-mode sequencer and its helpers
// assumes a 50 MHz system clock and a 32-bit APB register bus
package pwrseq_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned INIT_WAIT_US    = 1000;   // register initialisation, 1 ms
    localparam int unsigned WAKE_WAIT_US    = 1000;   // internal wake-up, 1 ms
    localparam int unsigned SLEEP_WAIT_US   = 6000;   // ramp-down and power-off, 6 ms
    localparam int unsigned INIT_CYCLES     = (CLK_HZ / 1_000_000) * INIT_WAIT_US;
    localparam int unsigned WAKE_CYCLES     = (CLK_HZ / 1_000_000) * WAKE_WAIT_US;
    localparam int unsigned SLEEP_CYCLES    = (CLK_HZ / 1_000_000) * SLEEP_WAIT_US;
    localparam int unsigned CNT_W           = 20;

    // register indices; the byte address is four times the index
    localparam logic [11:0] SLEEP_CTRL_IDX   = 12'h0002;
    localparam logic [11:0] IN_CH_EN_IDX     = 12'h0073;
    localparam logic [11:0] OUT_SLOT_EN_IDX  = 12'h0074;
    localparam logic [11:0] PWR_CTRL_IDX     = 12'h0075;
    localparam logic [11:0] STATUS_IDX       = 12'h0077;
    localparam logic [11:0] SAMPLE_IDX       = 12'h0080;   // test sample source, one value shared by all channels

    // field positions
    localparam int unsigned SLEEP_EN_BIT     = 0;
    localparam int unsigned PWR_ADC_BIT      = 7;
    localparam int unsigned PWR_BIAS_BIT     = 6;
    localparam int unsigned PWR_PLL_BIT      = 5;
    localparam int unsigned STAT_SLEEP_BIT   = 7;
    localparam int unsigned STAT_ACTIVE_BIT  = 6;
    localparam int unsigned STAT_LINK_BIT    = 5;

    // reset values
    localparam logic [7:0]  SLEEP_CTRL_RST   = 8'h01;
    localparam logic [7:0]  IN_CH_EN_RST     = 8'hF0;
    localparam logic [7:0]  OUT_SLOT_EN_RST  = 8'hF0;
    localparam logic [7:0]  PWR_CTRL_RST     = 8'h00;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b000,
        ST_INIT     = 3'b001,
        ST_SLEEP    = 3'b010,
        ST_WAKING   = 3'b011,
        ST_ACTIVE   = 3'b100,
        ST_RAMPDOWN = 3'b101
    } pwr_state_e;
endpackage

// ===== core/pwr_wait_timer.sv
// down-counter for the sequencer's millisecond waits
// assumes load and count come from logic on CLK
`timescale 1ns/1ps
module pwr_wait_timer #(
    parameter int unsigned W = 20
) (
    input  wire logic         CLK,
    input  wire logic         SRST,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_s;
    tmr_s st_r;
    tmr_s st_nxt;

    // load wins over counting; stops at zero
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = load_val;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = (st_r.cnt == '0) && !load;
endmodule

// ===== core/tdm_slot_tx.sv
// tdm serializer on the host's bit clock, 32-bit slots, msb first
// assumes frame sync is a one-bit-clock pulse taken on the rise that launches slot 0 bit 31
`timescale 1ns/1ps
module tdm_slot_tx #(
    parameter int unsigned SLOTS = 8
) (
    input  wire logic              BCLK,
    input  wire logic              FSYNC,
    input  wire logic              run_async,
    input  wire logic [SLOTS-1:0]  slot_en_async,
    input  wire logic [31:0]       sample_async,
    output logic                   sdout,
    output logic                   sdout_oe,
    output logic                   frame_tgl
);
    typedef struct packed {
        logic              run_m;
        logic              run_s;
        logic [4:0]        bit_i;
        logic [7:0]        slot;
        logic [31:0]       shift;
        logic              tgl;
        logic              oe;
        logic [SLOTS-1:0]  en_m;
        logic [SLOTS-1:0]  en_s;
        logic [31:0]       smp_m;
        logic [31:0]       smp_s;
    } tx_s;
    tx_s st_r;
    tx_s st_nxt;

    // quasi-static inputs from CLK pass two flip-flops before use
    always_comb begin
        st_nxt = st_r;
        st_nxt.run_m = run_async;
        st_nxt.run_s = st_r.run_m;
        st_nxt.en_m  = slot_en_async;
        st_nxt.en_s  = st_r.en_m;
        st_nxt.smp_m = sample_async;
        st_nxt.smp_s = st_r.smp_m;
        if (FSYNC) begin
            st_nxt.bit_i = 5'd31;
            st_nxt.slot  = '0;
            st_nxt.shift = st_r.smp_s;
            st_nxt.tgl   = ~st_r.tgl;
        end else if (st_r.bit_i == 5'd0) begin
            st_nxt.bit_i = 5'd31;
            st_nxt.slot  = st_r.slot + 8'd1;
            st_nxt.shift = st_r.smp_s;
        end else begin
            st_nxt.bit_i = st_r.bit_i - 5'd1;
            st_nxt.shift = {st_r.shift[30:0], 1'b0};
        end
        st_nxt.oe = st_r.run_s && (st_nxt.slot < SLOTS) && st_r.en_s[st_nxt.slot[2:0]]; // [RULE_08] [RULE_18]
    end

    always_ff @(posedge BCLK) begin
        st_r <= st_nxt;
    end

    assign sdout     = st_r.oe ? st_r.shift[31] : 1'b0;
    assign sdout_oe  = st_r.oe;
    assign frame_tgl = st_r.tgl;
endmodule

// ===== verif/host_link_model.sv
// host side of the audio link: bit clock, frame sync and slot capture
// assumes 8 slots of 32 bits, data launched on the bit clock rise
`timescale 1ns/1ps
module host_link_model (
    input  wire logic        run,
    input  wire logic        sdout,
    input  wire logic        sdout_oe,
    output logic             bclk,
    output logic             fsync,
    output logic [7:0][31:0] got_data,
    output logic [7:0]       got_oe,
    output int               frames
);
    logic [7:0][31:0] d;
    logic [7:0]       o;

    // a frame starts only while run is high and always runs whole; between frames the clock stands still while run is low
    initial begin
        bclk = 1'b0;
        fsync = 1'b0;
        frames = 0;
        got_data = '0;
        got_oe = '0;
        #7;
        forever begin
            wait (run === 1'b1);
            fsync = 1'b1;
            o = '0;
            // the rise that takes frame sync launches slot 0 bit 31; sample at each fall
            for (int k = 0; k < 256; k++) begin
                #40 bclk = 1'b1;
                #40 d[k/32][31-k%32] = sdout;
                o[k/32] = o[k/32] | sdout_oe;
                bclk = 1'b0;
                fsync = 1'b0;
            end
            got_data = d;
            got_oe = o;
            frames++;
        end
    end
endmodule

// ===== verif/audio_adc_power_mode_sequencer_test.sv
// self-checking bench: apb register traffic, pin control, tdm frames
// assumes shortened waits of 20/20/40 cycles and a host link model
`timescale 1ns/1ps
module audio_adc_power_mode_sequencer_test;
    import pwrseq_pkg::*;
    localparam int unsigned T_INIT = 20;
    localparam int unsigned T_WAKE = 20;
    localparam int unsigned T_SLP  = 40;
    logic             clk = 1'b0, srst = 1'b1, pin_n = 1'b0, run = 1'b0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]      paddr = '0;
    logic [31:0]      pwdata = '0, prdata, rd, smp;
    logic             pready, pslverr, bclk, fsync, sdout, sdout_oe, adc_on, bias_on, pll_on, er;
    logic [7:0][31:0] got_data;
    logic [7:0]       got_oe, in_en, out_en, pwr;
    int               frames, err_count = 0, compares = 0, seed = 32'h29de;

    pwr_mode_seq #(.INIT_CNT(T_INIT), .WAKE_CNT(T_WAKE), .SLEEP_CNT(T_SLP), .CHANNELS(8)) dut (
        .CLK(clk), .SRST(srst), .HW_SHUTDOWN_PIN_N(pin_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .BCLK(bclk), .FSYNC(fsync), .SDOUT(sdout), .SDOUT_OE(sdout_oe),
        .ADC_POWER_ON(adc_on), .MIC_BIAS_SUPPLY_ON(bias_on), .PLL_POWER_ON(pll_on));

    host_link_model host (.run(run), .sdout(sdout), .sdout_oe(sdout_oe), .bclk(bclk), .fsync(fsync),
        .got_data(got_data), .got_oe(got_oe), .frames(frames));

    // 50 MHz system clock
    always #10 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[9:0], 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rcheck(input logic [11:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask

    // slots that should carry data for a given configuration
    function automatic logic [7:0] slot_exp(input logic [7:0] i, input logic [7:0] o, input logic [7:0] p);
        return (p[PWR_ADC_BIT] && p[PWR_PLL_BIT] && (i != 8'h00)) ? (i & o) : 8'h00;
    endfunction

    // run two frames, judge the second one slot by slot
    task automatic stream(input logic [7:0] exp_oe, input logic [31:0] s);
        int f0;
        f0 = frames;
        @(posedge clk);
        run <= 1'b1;
        while (frames < f0 + 2) @(posedge clk);
        run <= 1'b0;
        for (int n = 0; n < 8; n++) begin
            check(32'(got_oe[n]), 32'(exp_oe[n]));
            if (exp_oe[n]) check(got_data[n], s);
        end
    endtask

    task automatic results();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog against a hung handshake or link
    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        results();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;                               // pin still low
        repeat (5) @(posedge clk);
        apb(1'b1, SLEEP_CTRL_IDX, 32'h0000_0000);
        rcheck(SLEEP_CTRL_IDX, 32'h0000_0001);
        check(32'({adc_on, bias_on, pll_on}), 32'h0);
        pin_n <= 1'b1;                              // supplies steady
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[STAT_SLEEP_BIT]), 32'h0);
        repeat (T_INIT + 10) @(posedge clk);
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[7:6]), 32'h2);
        rcheck(IN_CH_EN_IDX, 32'h0000_00F0);
        rcheck(OUT_SLOT_EN_IDX, 32'h0000_00F0);
        rcheck(PWR_CTRL_IDX, 32'h0000_0000);
        apb(1'b0, 12'h0FF, 32'h0000_0000);
        check(32'(er), 32'h1);
        apb(1'b1, STATUS_IDX, 32'h0000_0000);
        check(32'(er), 32'h1);
        apb(1'b1, SLEEP_CTRL_IDX, 32'h0000_0000);
        check(32'(er), 32'h0);
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[STAT_ACTIVE_BIT]), 32'h0);
        repeat (T_WAKE + 5) @(posedge clk);
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[7:6]), 32'h1);
        for (int i = 0; i < 6; i++) begin
            in_en = 8'($random(seed));
            out_en = 8'($random(seed));
            smp = $random(seed);
            pwr = 8'($random(seed)) & 8'hE0;
            if (i == 0) in_en = 8'h00;
            if (i == 1) {in_en, out_en, pwr} = 24'hFF_FFE0;
            if (i == 2) pwr = 8'h40;
            if (i == 5) {in_en, pwr} = {in_en | 8'h01, 8'hE0};
            apb(1'b1, IN_CH_EN_IDX, 32'(in_en));
            apb(1'b1, OUT_SLOT_EN_IDX, 32'(out_en));
            apb(1'b1, SAMPLE_IDX, smp);
            apb(1'b1, PWR_CTRL_IDX, 32'(pwr));
            @(posedge clk);
            check(32'({adc_on, bias_on, pll_on}), 32'(pwr[7:5]));
            stream(slot_exp(in_en, out_en, pwr), smp);
        end
        apb(1'b1, SLEEP_CTRL_IDX, 32'h0000_0001);
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[STAT_SLEEP_BIT]), 32'h0);
        repeat (T_SLP + 10) @(posedge clk);
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[7:6]), 32'h2);
        check(32'({adc_on, bias_on, pll_on}), 32'h0);
        stream(8'h00, smp);
        rcheck(IN_CH_EN_IDX, 32'(in_en));
        apb(1'b1, SLEEP_CTRL_IDX, 32'h0000_0000);
        repeat (T_WAKE + 5) @(posedge clk);
        stream(slot_exp(in_en, out_en, pwr), smp);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        check(32'({adc_on, bias_on, pll_on}), 32'h0);
        stream(8'h00, smp);
        rcheck(IN_CH_EN_IDX, 32'h0000_00F0);
        pin_n <= 1'b1;
        repeat (T_INIT + 10) @(posedge clk);
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[7:6]), 32'h2);
        apb(1'b1, SLEEP_CTRL_IDX, 32'h0000_0000);
        repeat (T_WAKE + 5) @(posedge clk);
        apb(1'b0, STATUS_IDX, 32'h0000_0000);
        check(32'(rd[7:6]), 32'h1);
        results();
    end
endmodule
